// ### tfsi_checker.sv
// Purpose: port assertions of the transfer fifo status block
// Assumes: one clock, sync reset, one wishbone request at a time
// Notes: bound to tfsi_top below
`default_nettype none
module tfsi_checker
  import tfsi_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // far side and interrupt
  input wire tfsi_tm_t tm_i,
  input wire logic halt_o,
  input wire tfsi_acc_t acc_i,
  input wire logic acceptor_hold_o,
  input wire logic nrfd_hold_o,
  input wire logic local_ready_o,
  input wire logic local_not_busy_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic wr8 = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  wire logic [5:0] idx = wb_adr_i[7:2];
  wire logic [7:0] wd = wb_dat_i[7:0];
  wire logic st_rd = wb_ack_o && !wb_we_i && idx == IDX_STATUS;
  // a release in the same cycle lets the holdoff drop legally
  wire logic rel_wr = wr8 && idx == IDX_AUX && wd == AUX_RELEASE_HOLDOFF;
  // flags lag their inputs, so the cause must stand a few cycles
  sequence s_halted; halt_o [*4]; endsequence
  sequence s_done; tm_i.done [*4]; endsequence
  property p_go; wr8 && idx == IDX_CMD && wd == CMD_GO |=> !halt_o; endproperty
  a_go: assert property (p_go) else $error("go left halt set");
  property p_stop; wr8 && idx == IDX_CMD && wd == CMD_STOP |=> halt_o; endproperty
  a_stop: assert property (p_stop) else $error("stop left halt clear");
  property p_quiet; halt_o && $past(halt_o) |-> !local_ready_o && !local_not_busy_o; endproperty
  a_quiet: assert property (p_quiet) else $error("local message while halted");
  property p_hold; wr8 && idx == IDX_AUX && wd == AUX_HOLDOFF_NOW |=> acceptor_hold_o; endproperty
  a_hold: assert property (p_hold) else $error("holdoff not set");
  property p_rel; wr8 && idx == IDX_AUX && wd == AUX_RELEASE_HOLDOFF |=> !acceptor_hold_o; endproperty
  a_rel: assert property (p_rel) else $error("holdoff not released");
  property p_nrfd;
    acceptor_hold_o && acc_i.acceptor_not_ready_state && !rel_wr |=> nrfd_hold_o;
  endproperty
  a_nrfd: assert property (p_nrfd) else $error("ready for data not held");
  property p_thr; s_halted ##0 st_rd |-> !wb_dat_o[BIT_THR]; endproperty
  a_thr: assert property (p_thr) else $error("threshold while halted");
  property p_nef; s_done ##0 st_rd |-> !wb_dat_o[BIT_NEF]; endproperty
  a_nef: assert property (p_nef) else $error("not empty while done");
  property p_irq; st_rd && wb_dat_o[BIT_INT] |-> irq_o; endproperty
  a_irq: assert property (p_irq) else $error("summary set without irq");
endmodule
bind tfsi_top tfsi_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tm_i(tm_i),
  .halt_o(halt_o), .acc_i(acc_i), .acceptor_hold_o(acceptor_hold_o),
  .nrfd_hold_o(nrfd_hold_o), .local_ready_o(local_ready_o),
  .local_not_busy_o(local_not_busy_o), .irq_o(irq_o));
`default_nettype wire

// ### tfsi_far_end.sv
// Purpose: far side model, transfer manager and acceptor
// Assumes: shares the block clock
// Notes: moves one byte every other cycle while running
`default_nettype none
module tfsi_far_end
  import tfsi_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // from the block
  input wire logic halt_i,
  input wire logic hold_i,
  // scenario controls
  input wire logic [5:0] fill_i,
  input wire logic move_i,
  input wire logic done_i,
  input wire logic core_i,
  input wire logic rdy_i,
  input wire logic nba_i,
  // to the block
  output tfsi_tm_t tm_o,
  output tfsi_acc_t acc_o
);
  logic pulse_q;
  logic ans_q;
  always_ff @(posedge clk_i) begin
    pulse_q <= !rst_i && move_i && !halt_i && !pulse_q;
    // parks in not-ready while held off or not asked to be ready
    ans_q <= rst_i || hold_i || !rdy_i;
  end
  assign tm_o = '{fill_i, pulse_q, done_i, core_i};
  assign acc_o = '{rdy_i, nba_i, ans_q};
endmodule
`default_nettype wire

// ### tfsi_flags.sv
// Purpose: level flags of the transfer fifo from occupancy, direction and halt
// Assumes: occupancy is given in bytes, at most 32
// Notes: flags are registered, one cycle behind their inputs
`default_nettype none
module tfsi_flags
  import tfsi_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fifo state and mode
  input wire logic [5:0] fifo_bytes_i,
  input wire logic receive_i,
  input wire logic wide_i,
  input wire logic halt_i,
  input wire logic done_i,
  // flags
  output tfsi_flags_t flags_o
);
  tfsi_flags_t flags_d;
  tfsi_flags_t flags_q;
  wire logic [5:0] words = wide_i ? {1'b0, fifo_bytes_i[5:1]} : fifo_bytes_i;
  wire logic [5:0] free_words = FIFO_WORDS - words;
  wire logic fill_met = words >= THR_WORDS;
  wire logic free_met = free_words >= THR_WORDS;
  wire logic odd_tail = (fifo_bytes_i == ONE_BYTE) && halt_i;

  assign flags_d.threshold_ready = ~halt_i & ((free_met & ~receive_i) | (fill_met & receive_i));
  assign flags_d.fifo_not_full = free_words >= ONE_WORD;
  // done overrides both the word and the odd-byte case
  assign flags_d.fifo_not_empty = ~done_i & ((words >= ONE_WORD) | odd_tail);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;
endmodule
`default_nettype wire

// ### tfsi_pkg.sv
// Purpose: shared constants and carrier types of the transfer fifo status block
// Assumes: 32-bit classic wishbone, register index = byte address / 4
// Notes: fifo is 16 positions of up to two bytes
`default_nettype none
package tfsi_pkg;
  // register indices
  localparam logic [5:0] IDX_MASK = 6'h02;
  localparam logic [5:0] IDX_AUX = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h1A;
  localparam logic [5:0] IDX_CMD = 6'h1C;
  localparam logic [5:0] IDX_CONFIG = 6'h20;
  localparam logic [5:0] IDX_COUNT = 6'h21;
  localparam logic [5:0] IDX_EVENT = 6'h22;
  localparam logic [5:0] IDX_EVMASK = 6'h23;
  // status and mask bit positions
  localparam int BIT_DONE = 0;
  localparam int BIT_CORE = 1;
  localparam int BIT_NEF = 2;
  localparam int BIT_NFF = 3;
  localparam int BIT_STOP = 4;
  localparam int BIT_THR = 6;
  localparam int BIT_INT = 7;
  localparam logic [7:0] COND_BITS = 8'h5F;
  // config bits
  localparam int CFG_RECEIVE = 0;
  localparam int CFG_WIDE = 1;
  localparam logic [7:0] CFG_BITS = 8'h03;
  // command codes
  localparam logic [7:0] AUX_HOLDOFF_NOW = 8'h51;
  localparam logic [7:0] AUX_RELEASE_HOLDOFF = 8'h03;
  localparam logic [7:0] CMD_GO = 8'h04;
  localparam logic [7:0] CMD_STOP = 8'h08;
  // reset values and counter constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h02;
  localparam logic [31:0] RST_COUNT = 32'hFFFFFFFF;
  localparam logic [31:0] COUNT_LAST = 32'hFFFFFFFF;
  localparam logic [31:0] COUNT_ONE = 32'h00000001;
  // fifo geometry, threshold is 75% of the words
  localparam logic [5:0] FIFO_WORDS = 6'h10;
  localparam logic [5:0] THR_WORDS = 6'h0C;
  localparam logic [5:0] ONE_WORD = 6'h01;
  localparam logic [5:0] ONE_BYTE = 6'h01;

  typedef struct packed {
    logic threshold_ready;
    logic fifo_not_full;
    logic fifo_not_empty;
  } tfsi_flags_t;

  typedef struct packed {
    logic [5:0] fifo_bytes;
    logic byte_moved;
    logic done;
    logic core_interrupt_pending;
  } tfsi_tm_t;

  typedef struct packed {
    logic ready_req;
    logic not_busy_req;
    logic acceptor_not_ready_state;
  } tfsi_acc_t;
endpackage
`default_nettype wire

// ### tfsi_tb_top.sv
// Purpose: register level tests of the transfer fifo status block
// Assumes: 200 MHz clock, classic wishbone master
// Notes: wide fifo, so words are half the byte occupancy
`default_nettype none
module tfsi_tb_top
  import tfsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, move = 1'b0, done = 1'b0;
  logic core = 1'b0, rdy = 1'b1, nba = 1'b1;
  logic [1:0] cs = 2'b00;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q;
  logic [5:0] fill = 6'h00;
  wire logic [31:0] rdat;
  wire logic ack, halt, hold, nrfd, lrdy, lnba, irq;
  wire tfsi_tm_t tm;
  wire tfsi_acc_t acc;
  int n_fail = 0, n_compared = 0, cycles = 0;
  tfsi_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cs[1]), .wb_stb_i(cs[0]),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tm_i(tm), .halt_o(halt), .acc_i(acc), .acceptor_hold_o(hold),
    .nrfd_hold_o(nrfd), .local_ready_o(lrdy), .local_not_busy_o(lnba), .irq_o(irq));
  tfsi_far_end far (.clk_i(clk_i), .rst_i(rst_i), .halt_i(halt), .hold_i(hold),
    .fill_i(fill), .move_i(move), .done_i(done), .core_i(core), .rdy_i(rdy),
    .nba_i(nba), .tm_o(tm), .acc_o(acc));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic give_verdict;
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, held until ack is sampled
  // no own limit: a missing ack is caught by the cycle ceiling
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    cs <= 2'b11;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cs <= 2'b00;
  endtask
  // flags reach status two cycles late, so let inputs settle first
  task automatic rd(input logic [5:0] idx, input string what, input logic [31:0] exp);
    repeat (4) @(posedge clk_i);
    bus(1'b0, idx, 32'h0);
    check(what, q, exp);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_MASK, "mask reset", 32'h0);
    rd(IDX_STATUS, "status idle", 32'h08);
    rd(6'h3F, "unmapped", 32'h0);
    bus(1'b1, IDX_MASK, 32'hFF);
    rd(IDX_MASK, "mask", {24'h0, COND_BITS});
    bus(1'b1, IDX_MASK, 32'h02);
    core <= 1'b1;
    rd(IDX_STATUS, "status core", 32'h8A);
    check("irq raised", {31'h0, irq}, 32'h1);
    bus(1'b1, IDX_MASK, 32'h0);
    rd(IDX_STATUS, "status masked", 32'h0A);
    bus(1'b1, IDX_EVMASK, 32'h02);
    core <= 1'b0;
    bus(1'b1, IDX_EVENT, 32'h02);
    rd(IDX_STATUS, "status cleared", 32'h08);
    check("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b1, IDX_CMD, {24'h0, CMD_GO});
    fill <= 6'h08;
    rd(IDX_STATUS, "send thr", 32'h4C);
    check("ready msg", {30'h0, lrdy, lnba}, 32'h3);
    fill <= 6'h0A;
    rd(IDX_STATUS, "send below thr", 32'h0C);
    bus(1'b1, IDX_CONFIG, 32'h03);
    fill <= 6'h18;
    rd(IDX_STATUS, "recv thr", 32'h4C);
    fill <= 6'h16;
    rd(IDX_STATUS, "recv below thr", 32'h0C);
    fill <= 6'h20;
    rd(IDX_STATUS, "full", 32'h44);
    fill <= 6'h18;
    bus(1'b1, IDX_CMD, {24'h0, CMD_STOP});
    rd(IDX_STATUS, "halted", 32'h1C);
    check("halt", {31'h0, halt}, 32'h1);
    fill <= 6'h01;
    rd(IDX_STATUS, "lone byte", 32'h1C);
    done <= 1'b1;
    rd(IDX_STATUS, "done", 32'h19);
    done <= 1'b0;
    fill <= 6'h00;
    bus(1'b1, IDX_COUNT, 32'hFFFFFFFE);
    move <= 1'b1;
    bus(1'b1, IDX_CMD, {24'h0, CMD_GO});
    for (int i = 0; i < 20 && halt !== 1'b1; i++) @(posedge clk_i);
    move <= 1'b0;
    rd(IDX_COUNT, "count", 32'h0);
    rd(IDX_STATUS, "count stop", 32'h18);
    bus(1'b1, IDX_AUX, {24'h0, AUX_HOLDOFF_NOW});
    repeat (3) @(posedge clk_i);
    check("holdoff", {30'h0, hold, nrfd}, 32'h3);
    bus(1'b1, IDX_AUX, {24'h0, AUX_RELEASE_HOLDOFF});
    repeat (3) @(posedge clk_i);
    check("release", {31'h0, hold}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ### tfsi_top.sv
// Purpose: status, mask and command registers of the transfer fifo
// Assumes: classic wishbone slave, 200 MHz single clock, sync reset
// Notes: fifo data path and acceptor machine live outside this block
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
// How it works
// - receiving and running, threshold flag set when fifo at least 75% full.
// - sending and running, threshold flag set when at least 75% free.
// - threshold flag is not-halted and direction-selected threshold, low when halted.
// - each status condition requests interrupt while true and its enable set.
// - mask register reads back stored enables, not live conditions.
// - stopped flag sets when count runs out or stop command written while running; a stop in idle after reset leaves it clear.
// - not-full flag set while room for one more word, else clear.
// - not-empty flag set while at least one whole word is held.
// - not-empty also set for one lone byte when halted and not done.
// - not-empty clears below one word while running, and whenever done.
// - auxiliary code 0x51 blocks acceptor from leaving not-ready state.
// - while held off in not-ready state, ready-for-data holdoff kept asserted.
// - auxiliary code 0x03 releases the ready-for-data holdoff.
// - command 0x04 clears halt and starts; halted forces ready, not-busy false.
// - command 0x08 sets halt and stops the transfer manager.
// - byte counter counts each moved byte; software loads negated byte count.
module tfsi_top
  import tfsi_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // transfer manager side
  input wire tfsi_tm_t tm_i,
  output logic halt_o,
  // acceptor side
  input wire tfsi_acc_t acc_i,
  output logic acceptor_hold_o,
  output logic nrfd_hold_o,
  output logic local_ready_o,
  output logic local_not_busy_o,
  // interrupt
  output logic irq_o
);
  typedef enum logic [2:0] {
    TM_IDLE = 3'b001,
    TM_RUN = 3'b010,
    TM_STOPPED = 3'b100
  } tfsi_tm_state_t;

  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = adr[7:2] == idx;
  endfunction

  tfsi_tm_state_t tm_q;
  tfsi_tm_state_t tm_d;
  logic [7:0] mask_q;
  logic [7:0] config_q;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic [7:0] event_q;
  logic [7:0] event_d;
  logic [7:0] evmask_q;
  logic [7:0] cond_q;
  logic holdoff_q;
  logic holdoff_d;
  logic ack_q;
  logic [31:0] dat_q;
  logic irq_q;
  logic halt_q;
  logic acc_hold_q;
  logic nrfd_q;
  logic rdy_q;
  logic nba_q;
  tfsi_flags_t flags;

  // bus decode
  wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic wr = req & wb_we_i;
  wire logic wr_lo = wr & wb_sel_i[0];
  wire logic wr_mask = wr_lo & hit(wb_adr_i, IDX_MASK);
  wire logic wr_aux = wr_lo & hit(wb_adr_i, IDX_AUX);
  wire logic wr_cmd = wr_lo & hit(wb_adr_i, IDX_CMD);
  wire logic wr_config = wr_lo & hit(wb_adr_i, IDX_CONFIG);
  wire logic wr_count = wr & hit(wb_adr_i, IDX_COUNT);
  wire logic wr_event = wr_lo & hit(wb_adr_i, IDX_EVENT);
  wire logic wr_evmask = wr_lo & hit(wb_adr_i, IDX_EVMASK);
  wire logic [7:0] wdat = wb_dat_i[7:0];

  // commands
  wire logic cmd_go = wr_cmd && (wdat == CMD_GO);
  wire logic cmd_stop = wr_cmd && (wdat == CMD_STOP);
  wire logic aux_hold = wr_aux && (wdat == AUX_HOLDOFF_NOW);
  wire logic aux_release = wr_aux && (wdat == AUX_RELEASE_HOLDOFF);

  // transfer manager
  wire logic running = tm_q == TM_RUN;
  wire logic halt = ~running;
  wire logic counting = running & tm_i.byte_moved;
  wire logic count_out = counting && (count_q == COUNT_LAST);

  // live conditions in status layout, summary bit left out here
  wire logic [7:0] cond_raw = {
    1'b0,
    flags.threshold_ready,
    1'b0,
    tm_q == TM_STOPPED,
    flags.fifo_not_full,
    flags.fifo_not_empty,
    tm_i.core_interrupt_pending,
    tm_i.done
  };
  wire logic [7:0] cond_en = cond_q & mask_q & COND_BITS;
  wire logic summary = |cond_en;
  wire logic [7:0] status = {summary, cond_q[6:0]};
  wire logic [7:0] rises = cond_raw & ~cond_q;

  tfsi_flags u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fifo_bytes_i(tm_i.fifo_bytes),
    .receive_i(config_q[CFG_RECEIVE]),
    .wide_i(config_q[CFG_WIDE]),
    .halt_i(halt),
    .done_i(tm_i.done),
    .flags_o(flags)
  );

  // run state: go starts, stop or exhausted count halts
  always_comb begin
    tm_d = tm_q;
    unique case (tm_q)
      TM_IDLE, TM_STOPPED: begin
        if (cmd_go) begin
          tm_d = TM_RUN;
        end
      end
      TM_RUN: begin
        if (cmd_stop || count_out) begin
          tm_d = TM_STOPPED;
        end
      end
    endcase
  end

  // counter write by byte lanes, hardware count on top
  always_comb begin
    count_d = count_q;
    for (int i = 0; i < 4; i++) begin
      if (wr_count && wb_sel_i[i]) begin
        count_d[8*i +: 8] = wb_dat_i[8*i +: 8];
      end
    end
    if (counting) begin
      count_d = count_q + COUNT_ONE;
    end
  end

  // sticky events: set beats the write-one clear
  assign event_d = (event_q & ~(wr_event ? wdat : RST_BYTE)) | (rises & COND_BITS);

  // holdoff: hold command wins if both could meet
  assign holdoff_d = aux_hold | (holdoff_q & ~aux_release);

  // read mux
  logic [31:0] rdat;
  always_comb begin
    rdat = '0;
    if (hit(wb_adr_i, IDX_MASK)) begin
      rdat[7:0] = mask_q;
    end else if (hit(wb_adr_i, IDX_STATUS)) begin
      rdat[7:0] = status;
    end else if (hit(wb_adr_i, IDX_CONFIG)) begin
      rdat[7:0] = config_q;
    end else if (hit(wb_adr_i, IDX_COUNT)) begin
      rdat = count_q;
    end else if (hit(wb_adr_i, IDX_EVENT)) begin
      rdat[7:0] = event_q;
    end else if (hit(wb_adr_i, IDX_EVMASK)) begin
      rdat[7:0] = evmask_q;
    end
  end

  // bus answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      dat_q <= (req & ~wb_we_i) ? rdat : '0;
    end
  end

  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= RST_BYTE;
      config_q <= RST_CONFIG;
      evmask_q <= RST_BYTE;
    end else begin
      if (wr_mask) begin
        mask_q <= wdat & COND_BITS;
      end
      if (wr_config) begin
        config_q <= wdat & CFG_BITS;
      end
      if (wr_evmask) begin
        evmask_q <= wdat & COND_BITS;
      end
    end
  end

  // block state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tm_q <= TM_IDLE;
      count_q <= RST_COUNT;
      event_q <= RST_BYTE;
      cond_q <= RST_BYTE;
      holdoff_q <= 1'b0;
    end else begin
      tm_q <= tm_d;
      count_q <= count_d;
      event_q <= event_d;
      cond_q <= cond_raw;
      holdoff_q <= holdoff_d;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_q <= 1'b1;
      acc_hold_q <= 1'b0;
      nrfd_q <= 1'b0;
      rdy_q <= 1'b0;
      nba_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      halt_q <= tm_d != TM_RUN;
      acc_hold_q <= holdoff_d;
      nrfd_q <= holdoff_d & acc_i.acceptor_not_ready_state;
      rdy_q <= (tm_d == TM_RUN) & ~holdoff_d & acc_i.ready_req;
      nba_q <= (tm_d == TM_RUN) & acc_i.not_busy_req;
      irq_q <= summary | |(event_q & evmask_q);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign halt_o = halt_q;
  assign acceptor_hold_o = acc_hold_q;
  assign nrfd_hold_o = nrfd_q;
  assign local_ready_o = rdy_q;
  assign local_not_busy_o = nba_q;
  assign irq_o = irq_q;
endmodule
`default_nettype wire
